/* hw/keep_reg.sv */
`timescale 1ns/100ps
module keep_reg #(
  parameter int              W    = 8,
  parameter logic [W-1:0]    FILL = '0
) (
  input  wire logic         pclk,    // System clock.
  input  wire logic         wr_en,   // Software write strobe.
  input  wire logic [W-1:0] wdata,   // Write data.
  input  wire logic         fill_en, // Load the undefined pattern.
  output logic      [W-1:0] q        // Stored value.
);

  // No reset on purpose: contents survive a reset taken in standby.
  always_ff @(posedge pclk) begin
    if (fill_en) begin
      q <= FILL;
    end else if (wr_en) begin
      q <= wdata;
    end
  end

endmodule : keep_reg

/* hw/reset_catch.sv */
`timescale 1ns/100ps
module reset_catch
  import reset_init_pkg::*;
(
  input  wire logic pclk,             // System clock.
  input  wire logic presetn,          // Asynchronous reset, active low.
  input  wire logic standby_mode,     // Device sits in a standby mode.
  output logic      init_pulse,       // High during reset and on the first cycle after its release.
  output logic      fill_pulse,       // Init cycle of a reset during operation.
  output logic      reset_in_standby  // Last reset arrived during standby.
);

  seq_state_t state;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_INIT;
    end else begin
      case (state)
        ST_INIT: state <= ST_RUN;
        ST_RUN:  state <= ST_RUN;
        default: state <= ST_INIT;
      endcase
    end
  end

  assign init_pulse = (state == ST_INIT);
  // The standby level is still held on the release cycle, so it is caught there.
  assign fill_pulse = init_pulse && !standby_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_in_standby <= 1'b0;
    end else if (init_pulse) begin
      reset_in_standby <= standby_mode;
    end
  end

endmodule : reset_catch

/* hw/reset_init_pkg.sv */
package reset_init_pkg;

  // ===========================================================================
  // Bus geometry
  // ===========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ===========================================================================
  // Register byte offsets
  // ===========================================================================
  localparam logic [7:0] OFS_SER_MODE0   = 8'h00;
  localparam logic [7:0] OFS_SER_BUSCTL  = 8'h04;
  localparam logic [7:0] OFS_SER_SHIFT0  = 8'h08;
  localparam logic [7:0] OFS_SLAVE_ADDR  = 8'h0C;
  localparam logic [7:0] OFS_ADC         = 8'h10;
  localparam logic [7:0] OFS_CLOCK_CTRL  = 8'h14;
  localparam logic [7:0] OFS_SER_MODE1   = 8'h18;
  localparam logic [7:0] OFS_SER_SHIFT1  = 8'h1C;
  localparam logic [7:0] OFS_IRQ         = 8'h20;
  localparam logic [7:0] OFS_EXT_MODE    = 8'h24;
  localparam logic [7:0] OFS_PORT_DIR    = 8'h28;
  localparam logic [7:0] OFS_PULLUP      = 8'h2C;
  localparam logic [7:0] OFS_PORT_LATCH  = 8'h30;
  localparam logic [7:0] OFS_TIMER       = 8'h34;
  localparam logic [7:0] OFS_PULSE_MOD   = 8'h38;
  localparam logic [7:0] OFS_STATUS      = 8'h3C;
  localparam logic [7:0] OFS_BSB_BASE    = 8'h40;
  localparam logic [7:0] OFS_RAM_BASE    = 8'h50;

  // ===========================================================================
  // Reset values and fill pattern
  // ===========================================================================
  localparam logic [7:0]  ADC_MODE_RESET   = 8'h04;
  localparam int          ADC_EOC_BIT      = 2;
  localparam logic [7:0]  EVT_MODULO_RESET = 8'hFF;
  localparam logic [15:0] PORT_LATCH_RESET = 16'h0002;
  localparam logic [15:0] UNDEF_FILL       = 16'hA5C3;
  localparam int          BSB_COUNT        = 4;
  localparam int          RAM_NIBBLES      = 6;

  // ===========================================================================
  // Reset sequencing states
  // ===========================================================================
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN  = 2'b01
  } seq_state_t;

endpackage : reset_init_pkg

/* hw/reset_state_init.sv */
// Contract
// - Six data nibbles at 0F8H-0FDH are undefined after every reset.
// - Channel-0 shift register held in standby reset, undefined otherwise.
// - Slave address register held in standby reset, undefined otherwise.
// - Channel-0 mode and serial bus control registers clear on reset.
// - A/D mode loads 04H, completion flag one; SA register undefined.
// - Processor clock, system clock and clock output mode clear on reset.
// - Channel-1 mode clears; channel-1 shift register held only in standby.
// - Serial transfer-done flag clears on reset.
// - All interrupt request flags clear on any reset.
// - All interrupt enables and the global enable clear on reset.
// - The three external interrupt mode registers clear on reset.
// - Port direction, output buffers and output latches clear on reset; here the output latches load 0002H (PORT_LATCH_RESET).
// - Pull-up selection clears, no pull-up selected.
// - Pulse generator modulo registers keep contents across any reset.
// - Watch timer mode register clears on reset.
// - Four bit sequential buffers held in standby reset, undefined otherwise.
// - Reset ending standby runs as a normal reset with standby values.
`timescale 1ns/100ps
module reset_state_init
  import reset_init_pkg::*;
(
  input  wire logic                            pclk,             // System clock.
  input  wire logic                            presetn,          // Reset, active low.
  input  wire logic                            psel,             // APB select.
  input  wire logic                            penable,          // APB enable.
  input  wire logic                            pwrite,           // APB direction.
  input  wire logic [reset_init_pkg::ADDR_W-1:0] paddr,          // APB address.
  input  wire logic [reset_init_pkg::DATA_W-1:0] pwdata,         // APB write data.
  output logic      [reset_init_pkg::DATA_W-1:0] prdata,         // APB read data.
  output logic                                 pready,           // APB ready.
  output logic                                 pslverr,          // APB error.
  input  wire logic                            standby_mode,     // Standby level.
  input  wire logic [7:0]                      irq_events,       // Request set pulses.
  input  wire logic                            xfer_done_evt,    // Transfer end pulse.
  output logic      [15:0]                     port_out,         // Port latches.
  output logic      [15:0]                     port_oe,          // Port buffer enables.
  output logic      [7:0]                      pullup_en,        // Pull-up selects.
  output logic                                 reset_in_standby  // Standby at reset.
);
  import reset_init_pkg::*;

  // ===========================================================================
  // Reset sequencing
  // ===========================================================================
  logic init_pulse;
  logic fill_pulse;

  reset_catch u_catch (
    .pclk             (pclk),
    .presetn          (presetn),
    .standby_mode     (standby_mode),
    .init_pulse       (init_pulse),
    .fill_pulse       (fill_pulse),
    .reset_in_standby (reset_in_standby)
  );

  // ===========================================================================
  // APB slave
  // ===========================================================================
  logic              wr_acc;
  logic              wr_ser_shift0;
  logic              wr_slave_addr;
  logic              wr_ser_shift1;
  logic              wr_sa;
  logic [DATA_W-1:0] rd_mux;
  logic              rd_hit;

  // A write lands only at the edge where the master samples pready high.
  assign wr_acc        = psel && penable && pready && pwrite;
  assign wr_ser_shift0 = wr_acc && (paddr == OFS_SER_SHIFT0);
  assign wr_slave_addr = wr_acc && (paddr == OFS_SLAVE_ADDR);
  assign wr_ser_shift1 = wr_acc && (paddr == OFS_SER_SHIFT1);
  assign wr_sa         = wr_acc && (paddr == OFS_ADC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable && !pready;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : '0;
      pslverr <= psel && !penable && !rd_hit;
    end
  end

  // ===========================================================================
  // Registers without a reset value: standby-held ones and the SAR
  // ===========================================================================
  logic [7:0] serial_shift_ch0;
  logic [7:0] slave_addr_reg;
  logic [7:0] serial_shift_ch1;
  logic [7:0] adc_sar;

  keep_reg #(.W(8), .FILL(UNDEF_FILL[7:0])) u_serial_shift_ch0 (
    .pclk    (pclk),
    .wr_en   (wr_ser_shift0),
    .wdata   (pwdata[7:0]),
    .fill_en (fill_pulse),
    .q       (serial_shift_ch0)
  );

  keep_reg #(.W(8), .FILL(UNDEF_FILL[15:8])) u_sva (
    .pclk    (pclk),
    .wr_en   (wr_slave_addr),
    .wdata   (pwdata[7:0]),
    .fill_en (fill_pulse),
    .q       (slave_addr_reg)
  );

  keep_reg #(.W(8), .FILL(UNDEF_FILL[7:0])) u_serial_shift_ch1 (
    .pclk    (pclk),
    .wr_en   (wr_ser_shift1),
    .wdata   (pwdata[7:0]),
    .fill_en (fill_pulse),
    .q       (serial_shift_ch1)
  );

  // The conversion result is undefined after any reset, standby or not.
  keep_reg #(.W(8), .FILL(UNDEF_FILL[15:8])) u_sar (
    .pclk    (pclk),
    .wr_en   (wr_sa),
    .wdata   (pwdata[15:8]),
    .fill_en (init_pulse),
    .q       (adc_sar)
  );

  // ===========================================================================
  // Bit sequential buffers and scratch nibbles
  // ===========================================================================
  logic [15:0] bit_seq_buffer [BSB_COUNT];
  logic [3:0]  ram_nibble     [RAM_NIBBLES];

  generate
    for (genvar i = 0; i < BSB_COUNT; i++) begin : g_bsb
      keep_reg #(.W(16), .FILL(UNDEF_FILL)) u_bsb (
        .pclk    (pclk),
        .wr_en   (wr_acc && (paddr == OFS_BSB_BASE + 8'(4 * i))),
        .wdata   (pwdata[15:0]),
        .fill_en (fill_pulse),
        .q       (bit_seq_buffer[i])
      );
    end
    for (genvar j = 0; j < RAM_NIBBLES; j++) begin : g_ram
      keep_reg #(.W(4), .FILL(UNDEF_FILL[3:0])) u_nib (
        .pclk    (pclk),
        .wr_en   (wr_acc && (paddr == OFS_RAM_BASE + 8'(4 * j))),
        .wdata   (pwdata[3:0]),
        .fill_en (init_pulse),
        .q       (ram_nibble[j])
      );
    end
  endgenerate

  // Modulo registers have no reset at all and so are held across any reset.
  logic [7:0] pulse_gen_modulo_low;
  logic [7:0] pulse_gen_modulo_high;
  logic       pulse_mod_loaded;

  // Only the hold check reads this; the pair is unknown until software loads it.
  always_ff @(posedge pclk) begin
    if (wr_acc && (paddr == OFS_PULSE_MOD)) begin
      pulse_mod_loaded <= 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_acc && (paddr == OFS_PULSE_MOD)) begin
      pulse_gen_modulo_low  <= pwdata[7:0];
      pulse_gen_modulo_high <= pwdata[15:8];
    end
  end

  // ===========================================================================
  // Registers with a defined reset value
  // ===========================================================================
  logic [7:0]  serial_mode_ch0;
  logic [7:0]  serial_bus_control;
  logic [7:0]  adc_mode_reg;
  logic [3:0]  processor_clock_ctrl;
  logic [3:0]  system_clock_ctrl;
  logic [3:0]  clock_out_mode;
  logic [7:0]  serial_mode_ch1;
  logic [3:0]  ext_irq0_mode;
  logic [3:0]  ext_irq1_mode;
  logic [3:0]  ext_irq2_mode;
  logic [7:0]  port_dir_group_a;
  logic [7:0]  port_dir_group_b;
  logic [7:0]  port_dir_group_c;
  logic [7:0]  event_counter_modulo;
  logic [7:0]  watch_timer_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_ch0      <= '0;
      serial_bus_control   <= '0;
      adc_mode_reg         <= ADC_MODE_RESET;
      processor_clock_ctrl <= '0;
      system_clock_ctrl    <= '0;
      clock_out_mode       <= '0;
      serial_mode_ch1      <= '0;
      ext_irq0_mode        <= '0;
      ext_irq1_mode        <= '0;
      ext_irq2_mode        <= '0;
      port_dir_group_a     <= '0;
      port_dir_group_b     <= '0;
      port_dir_group_c     <= '0;
      pullup_en            <= '0;
      port_out             <= PORT_LATCH_RESET;
      event_counter_modulo <= EVT_MODULO_RESET;
      watch_timer_mode     <= '0;
    end else if (wr_acc) begin
      case (paddr)
        OFS_SER_MODE0:  serial_mode_ch0    <= pwdata[7:0];
        OFS_SER_BUSCTL: serial_bus_control <= pwdata[7:0];
        OFS_ADC:        adc_mode_reg       <= pwdata[7:0];
        OFS_CLOCK_CTRL: begin
          processor_clock_ctrl <= pwdata[3:0];
          system_clock_ctrl    <= pwdata[7:4];
          clock_out_mode       <= pwdata[11:8];
        end
        OFS_SER_MODE1:  serial_mode_ch1 <= pwdata[7:0];
        OFS_EXT_MODE: begin
          ext_irq0_mode <= pwdata[3:0];
          ext_irq1_mode <= pwdata[7:4];
          ext_irq2_mode <= pwdata[11:8];
        end
        OFS_PORT_DIR: begin
          port_dir_group_a <= pwdata[7:0];
          port_dir_group_b <= pwdata[15:8];
          port_dir_group_c <= pwdata[23:16];
        end
        OFS_PULLUP:     pullup_en <= pwdata[7:0];
        OFS_PORT_LATCH: port_out  <= pwdata[15:0];
        OFS_TIMER: begin
          event_counter_modulo <= pwdata[7:0];
          watch_timer_mode     <= pwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  // Buffers follow the direction groups a and b, one cycle late.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_oe <= '0;
    end else begin
      port_oe <= {port_dir_group_b, port_dir_group_a};
    end
  end

  // ===========================================================================
  // Interrupt and transfer flags
  // ===========================================================================
  logic [7:0] irq_request_flags;
  logic [7:0] irq_enable_flags;
  logic       global_irq_enable;
  logic       transfer_done_flag;
  logic       wr_irq;

  assign wr_irq = wr_acc && (paddr == OFS_IRQ);

  // Write one to clear; a set in the same cycle wins so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_flags  <= '0;
      transfer_done_flag <= 1'b0;
    end else begin
      irq_request_flags <= (irq_request_flags & ~(wr_irq ? pwdata[7:0] : 8'h00))
                           | irq_events;
      if (xfer_done_evt) begin
        transfer_done_flag <= 1'b1;
      end else if (wr_acc && (paddr == OFS_SER_MODE1) && pwdata[8]) begin
        transfer_done_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_flags  <= '0;
      global_irq_enable <= 1'b0;
    end else if (wr_irq) begin
      irq_enable_flags  <= pwdata[15:8];
      global_irq_enable <= pwdata[16];
    end
  end

  // ===========================================================================
  // Read decode
  // ===========================================================================
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (paddr)
      OFS_SER_MODE0:  rd_mux[7:0]  = serial_mode_ch0;
      OFS_SER_BUSCTL: rd_mux[7:0]  = serial_bus_control;
      OFS_SER_SHIFT0: rd_mux[7:0]  = serial_shift_ch0;
      OFS_SLAVE_ADDR: rd_mux[7:0]  = slave_addr_reg;
      OFS_ADC:        rd_mux[15:0] = {adc_sar, adc_mode_reg};
      OFS_CLOCK_CTRL: rd_mux[11:0] = {clock_out_mode, system_clock_ctrl, processor_clock_ctrl};
      OFS_SER_MODE1:  rd_mux[8:0]  = {transfer_done_flag, serial_mode_ch1};
      OFS_SER_SHIFT1: rd_mux[7:0]  = serial_shift_ch1;
      OFS_IRQ:        rd_mux[16:0] = {global_irq_enable, irq_enable_flags, irq_request_flags};
      OFS_EXT_MODE:   rd_mux[11:0] = {ext_irq2_mode, ext_irq1_mode, ext_irq0_mode};
      OFS_PORT_DIR:   rd_mux[23:0] = {port_dir_group_c, port_dir_group_b, port_dir_group_a};
      OFS_PULLUP:     rd_mux[7:0]  = pullup_en;
      OFS_PORT_LATCH: rd_mux[15:0] = port_out;
      OFS_TIMER:      rd_mux[15:0] = {watch_timer_mode, event_counter_modulo};
      OFS_PULSE_MOD:  rd_mux[15:0] = {pulse_gen_modulo_high, pulse_gen_modulo_low};
      OFS_STATUS:     rd_mux[0]    = reset_in_standby;
      default: begin
        rd_hit = 1'b0;
        for (int k = 0; k < BSB_COUNT; k++) begin
          if (paddr == OFS_BSB_BASE + 8'(4 * k)) begin
            rd_mux[15:0] = bit_seq_buffer[k];
            rd_hit       = 1'b1;
          end
        end
        for (int m = 0; m < RAM_NIBBLES; m++) begin
          if (paddr == OFS_RAM_BASE + 8'(4 * m)) begin
            rd_mux[3:0] = ram_nibble[m];
            rd_hit      = 1'b1;
          end
        end
      end
    endcase
  end

  // ===========================================================================
  // Checks
  // ===========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence init_in_standby_s;
    init_pulse && standby_mode;
  endsequence

  sequence init_in_operation_s;
    init_pulse && !standby_mode;
  endsequence

  serial_ctl_clear_a : assert property (init_pulse |-> serial_mode_ch0 == 8'h00 && serial_bus_control == 8'h00) else $error("serial control not clear after reset");
  adc_mode_init_a : assert property (init_pulse |-> adc_mode_reg == ADC_MODE_RESET && adc_mode_reg[ADC_EOC_BIT]) else $error("adc mode wrong after reset");
  sar_undef_a : assert property (init_pulse |=> adc_sar == UNDEF_FILL[15:8]) else $error("conversion result not filled");
  shift0_hold_a : assert property (init_in_standby_s |=> serial_shift_ch0 == $past(serial_shift_ch0) && slave_addr_reg == $past(slave_addr_reg)) else $error("standby contents lost");
  shift0_fill_a : assert property (init_in_operation_s |=> serial_shift_ch0 == UNDEF_FILL[7:0] && bit_seq_buffer[0] == UNDEF_FILL) else $error("operation reset did not fill");
  ram_nibble_undef_a : assert property (init_pulse |=> ram_nibble[5] == UNDEF_FILL[3:0]) else $error("scratch nibble not filled");
  irq_set_wins_a : assert property (irq_events[0] |=> irq_request_flags[0]) else $error("request lost against clear");
  irq_clear_init_a : assert property (init_pulse |-> irq_request_flags == 8'h00 && !global_irq_enable && irq_enable_flags == 8'h00) else $error("interrupt state not clear");
  port_init_a : assert property (init_pulse |-> port_oe == 16'h0000 && port_out == PORT_LATCH_RESET && pullup_en == 8'h00) else $error("port state wrong after reset");
  modulo_hold_a : assert property (init_pulse && pulse_mod_loaded |=> pulse_gen_modulo_low == $past(pulse_gen_modulo_low) && pulse_gen_modulo_high == $past(pulse_gen_modulo_high)) else $error("modulo lost across reset");
  evt_modulo_init_a : assert property (init_pulse |-> event_counter_modulo == EVT_MODULO_RESET && watch_timer_mode == 8'h00) else $error("timer reset value wrong");
  standby_record_a : assert property (init_pulse && presetn |=> reset_in_standby == $past(standby_mode)) else $error("standby record wrong");

endmodule : reset_state_init

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import reset_init_pkg::*;
  // ===========================================================================
  // Stimulus, clock and result bookkeeping
  // ===========================================================================
  typedef struct {logic [7:0] a; logic [31:0] e; logic [31:0] m;} row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, irq_events = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, standby_mode = 1'b0, xfer_done_evt = 1'b0, rs, er;
  logic [15:0] port_out, port_oe;
  logic [7:0]  pullup_en;
  int          fail_count = 0, n_tests = 0, cycles = 0;
  row_t        rows[12];

  reset_state_init dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby_mode(standby_mode), .irq_events(irq_events),
    .xfer_done_evt(xfer_done_evt), .port_out(port_out), .port_oe(port_oe),
    .pullup_en(pullup_en), .reset_in_standby(rs));

  always #5 pclk = ~pclk;

  // A hang anywhere is cut here; the limit is far above the real run length.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // With eq low the value must differ: an undefined register may not keep old data.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input bit eq);
    n_tests++;
    if (eq ? (g !== e) : (g === e)) begin
      fail_count++;
      $display("MISMATCH %s expected %s%h seen %h", nm, eq ? "" : "not ", e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input bit eq);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), e, rd & m, eq);
  endtask : rchk

  task automatic do_reset(input logic sb);
    @(posedge pclk);
    presetn <= 1'b0; standby_mode <= sb;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    standby_mode <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  task automatic pulse();
    @(posedge pclk);
    irq_events <= 8'hA5; xfer_done_evt <= 1'b1;
    @(posedge pclk);
    irq_events <= 8'h00; xfer_done_evt <= 1'b0;
  endtask : pulse

  // ===========================================================================
  // Main sequence
  // ===========================================================================
  initial begin
    rows = '{'{8'h00, 0, '1}, '{8'h04, 0, '1}, '{8'h10, 32'h04, 32'hFF},
             '{8'h14, 0, '1}, '{8'h18, 0, '1}, '{8'h20, 0, '1},
             '{8'h24, 0, '1}, '{8'h28, 0, '1}, '{8'h2C, 0, '1},
             '{8'h30, 32'h2, '1}, '{8'h34, 32'hFF, '1}, '{8'h3C, 0, '1}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    foreach (rows[i]) rchk(rows[i].a, rows[i].e, rows[i].m, 1);
    $display("Test reset_table done");
    chk("port_out", 32'h2, {16'h0, port_out}, 1);
    chk("port_oe", 32'h0, {16'h0, port_oe}, 1);
    chk("pullup_en", 32'h0, {24'h0, pullup_en}, 1);
    apb(1'b1, 8'h28, 32'h3C5A);
    apb(1'b1, 8'h2C, 32'hA5);
    @(posedge pclk);
    chk("port_oe", 32'h3C5A, {16'h0, port_oe}, 1);
    chk("pullup_en", 32'hA5, {24'h0, pullup_en}, 1);
    $display("Test ports done");
    pulse();
    rchk(8'h20, 32'hA5, '1, 1);
    rchk(8'h18, 32'h100, '1, 1);
    apb(1'b1, 8'h20, 32'h1FFFF);
    rchk(8'h20, 32'h1FF00, '1, 1);
    apb(1'b0, 8'hF0, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er}, 1);
    chk("unmapped_data", 32'h0, rd, 1);
    // The request pulse is timed to meet the clearing write at the same edge.
    fork
      apb(1'b1, 8'h20, 32'hFF);
      begin
        @(posedge pclk);
        pulse();
      end
    join
    rchk(8'h20, 32'hA5, '1, 1);
    $display("Test flags done");
    apb(1'b1, 8'h08, 32'h5A);
    apb(1'b1, 8'h0C, 32'h5A);
    apb(1'b1, 8'h1C, 32'h5A);
    apb(1'b1, 8'h40, 32'h1234);
    apb(1'b1, 8'h38, 32'h1357);
    apb(1'b1, 8'h50, 32'h5);
    apb(1'b1, 8'h00, 32'h3F);
    apb(1'b1, 8'h14, 32'hFFF);
    pulse();
    do_reset(1'b1);
    rchk(8'h08, 32'h5A, '1, 1);
    rchk(8'h1C, 32'h5A, '1, 1);
    rchk(8'h40, 32'h1234, '1, 1);
    rchk(8'h38, 32'h1357, '1, 1);
    rchk(8'h0C, 32'h5A, '1, 1);
    rchk(8'h50, 32'h5, '1, 0);
    rchk(8'h3C, 32'h1, '1, 1);
    chk("reset_in_standby", 32'h1, {31'h0, rs}, 1);
    rchk(8'h00, 32'h0, '1, 1);
    rchk(8'h14, 32'h0, '1, 1);
    rchk(8'h20, 32'h0, '1, 1);
    rchk(8'h18, 32'h0, '1, 1);
    chk("port_oe", 32'h0, {16'h0, port_oe}, 1);
    $display("Test standby_reset done");
    do_reset(1'b0);
    rchk(8'h08, 32'h5A, '1, 0);
    rchk(8'h1C, 32'h5A, '1, 0);
    rchk(8'h0C, 32'h5A, '1, 0);
    rchk(8'h40, 32'h1234, '1, 0);
    rchk(8'h38, 32'h1357, '1, 1);
    rchk(8'h3C, 32'h0, '1, 1);
    chk("reset_in_standby", 32'h0, {31'h0, rs}, 1);
    $display("Test run_reset done");
    end_of_test();
  end
endmodule : tb_top
